// >>> pkg/xmp_pkg.sv
// Constants and types of the external memory pin port.
package xmp_pkg;

    // Pin widths.
    localparam int unsigned ADDR_W  = 24;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned BANK_W  = 2;
    localparam int unsigned BANKS   = 4;
    localparam int unsigned FLAG_N  = 4;
    localparam int unsigned PAR_LO  = 8;
    localparam int unsigned PAR_W   = DATA_W - PAR_LO;
    localparam int unsigned FUNC_W  = 2;

    // Reset values of the pin-side registers.
    localparam logic [ADDR_W-1:0] ADDR_RST      = 24'h00_0000;
    localparam logic [BANKS-1:0]  SEL_IDLE      = 4'hf;
    localparam logic [FLAG_N-1:0] FLAG_MODE_RST = 4'hf;

    // Least strobe width, and its count of clock cycles, rounded up.
    localparam int unsigned CLK_NS     = 25;
    localparam int unsigned STROBE_NS  = 50;
    localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CNT_W      = 2;

    // Depth of the read data buffer.
    localparam int unsigned FIFO_DEPTH = 8;

    // Per-pin function of a data pin.
    typedef enum logic [FUNC_W-1:0] {
        XMP_FUNC_MEM    = 2'h0,
        XMP_FUNC_PAR_IN = 2'h1,
        XMP_FUNC_FLAG   = 2'h2,
        XMP_FUNC_PWM    = 2'h3
    } xmp_func_t;

    // Access sequencer states, Gray coded along idle, strobe, wait, done.
    typedef enum logic [1:0] {
        XMP_ST_IDLE   = 2'h0,
        XMP_ST_STROBE = 2'h1,
        XMP_ST_WAIT   = 2'h3,
        XMP_ST_DONE   = 2'h2
    } xmp_state_t;

endpackage

// >>> design/xmp_fifo.sv
// Synchronous valid/ready FIFO used to buffer words read from external memory.
module xmp_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset.
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    // Filling side.
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Draining side.
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W:0]   count_q;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready_o  = (count_q != (PTR_W+1)'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o  = mem_q[rd_ptr_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Storage array; written only on an accepted push.
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    // Pointers wrap at the depth so that depths other than powers of two work.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
        end
    end

    // Occupancy count.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            count_q <= '0;
        end else if (push && !pop) begin
            count_q <= count_q + 1'b1;
        end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
        end
    end

endmodule // xmp_fifo

// >>> design/xmp_port.sv
// External memory pin port: asynchronous access sequencer and data pin sharing.
module xmp_port (
    // Clock and reset.
    input  wire logic                                 clock_i,
    input  wire logic                                 rst_n_i,
    // Access requests from the core.
    input  wire logic                                 req_valid_i,
    output logic                                      req_ready_o,
    input  wire logic                                 req_write_i,
    input  wire logic                                 req_cond_i,
    input  wire logic [xmp_pkg::BANK_W-1:0]           req_bank_i,
    input  wire logic [xmp_pkg::ADDR_W-1:0]           req_addr_i,
    input  wire logic [xmp_pkg::DATA_W-1:0]           req_wdata_i,
    output logic                                      done_o,
    // Read data towards the core.
    output logic                                      rd_valid_o,
    input  wire logic                                 rd_ready_i,
    output logic      [xmp_pkg::DATA_W-1:0]           rd_data_o,
    // Data pin function control.
    input  wire logic                                 func_we_i,
    input  wire logic [xmp_pkg::DATA_W*xmp_pkg::FUNC_W-1:0] func_sel_i,
    input  wire logic [xmp_pkg::FLAG_N-1:0]           flag_mode_i,
    output logic      [xmp_pkg::FLAG_N-1:0]           flag_mode_o,
    // Parallel input, flags and PWM sharing the data pins.
    input  wire logic                                 par_in_en_i,
    output logic      [xmp_pkg::PAR_W-1:0]            par_in_word_o,
    output logic                                      par_in_valid_o,
    input  wire logic [xmp_pkg::DATA_W-1:0]           flag_out_i,
    input  wire logic [xmp_pkg::DATA_W-1:0]           flag_oe_i,
    input  wire logic [xmp_pkg::DATA_W-1:0]           pwm_i,
    output logic      [xmp_pkg::DATA_W-1:0]           flag_in_o,
    // External memory pins.
    output logic      [xmp_pkg::ADDR_W-1:0]           addr_o,
    output logic                                      addr_oe_o,
    output logic      [xmp_pkg::BANKS-1:0]            memory_select_n_o,
    output logic                                      rd_n_o,
    output logic                                      wr_n_o,
    input  wire logic                                 ack_i,
    input  wire logic [xmp_pkg::DATA_W-1:0]           data_i,
    output logic      [xmp_pkg::DATA_W-1:0]           data_o,
    output logic      [xmp_pkg::DATA_W-1:0]           data_oe_o
);
    import xmp_pkg::*;

    xmp_state_t          state_q;
    logic [CNT_W-1:0]    cnt_q;
    logic                write_q;
    logic                cond_q;
    logic [DATA_W-1:0]   wdata_q;
    logic [DATA_W-1:0]   rdata_q;
    logic                ack_q1;
    logic                ack_q2;
    logic [DATA_W-1:0]   din_q1;
    logic [DATA_W-1:0]   din_q2;
    logic [DATA_W*FUNC_W-1:0] func_q;
    logic                fifo_in_ready;
    logic                accept;
    logic                mem_drive;

    // A read needs buffer room up front, so a stalled reader blocks new reads.
    assign req_ready_o = (state_q == XMP_ST_IDLE) && (req_write_i || fifo_in_ready);
    assign accept      = req_valid_i && req_ready_o;
    assign mem_drive   = write_q && cond_q &&
                         ((state_q == XMP_ST_STROBE) || (state_q == XMP_ST_WAIT));

    // Two-stage synchronisers for the asynchronous pins.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ack_q1 <= 1'b0;
            ack_q2 <= 1'b0;
            din_q1 <= '0;
            din_q2 <= '0;
        end else begin
            ack_q1 <= ack_i;
            ack_q2 <= ack_q1;
            din_q1 <= data_i;
            din_q2 <= din_q1;
        end
    end

    // Access sequencer: strobe for the least width, then wait for acknowledge.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_q <= XMP_ST_IDLE;
            cnt_q   <= '0;
        end else begin
            unique case (state_q)
                XMP_ST_IDLE: begin
                    if (accept) begin
                        state_q <= XMP_ST_STROBE;
                        cnt_q   <= CNT_W'(STROBE_CYC - 1);
                    end
                end
                XMP_ST_STROBE: begin
                    if (cnt_q == '0) begin
                        state_q <= XMP_ST_WAIT;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                XMP_ST_WAIT: begin
                    if (ack_q2) begin
                        state_q <= XMP_ST_DONE;
                    end
                end
                XMP_ST_DONE: begin
                    state_q <= XMP_ST_IDLE;
                end
            endcase
        end
    end

    // Request capture and the address, select and strobe pins.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            write_q   <= 1'b0;
            cond_q    <= 1'b0;
            wdata_q   <= '0;
            addr_o    <= ADDR_RST;
            addr_oe_o <= 1'b0;
            memory_select_n_o <= SEL_IDLE;
            rd_n_o    <= 1'b1;
            wr_n_o    <= 1'b1;
        end else begin
            addr_oe_o <= 1'b1;
            if (accept) begin
                write_q <= req_write_i;
                cond_q  <= req_cond_i;
                wdata_q <= req_wdata_i;
                addr_o  <= req_addr_i;
                memory_select_n_o <= SEL_IDLE & ~(BANKS'(1) << req_bank_i);
                rd_n_o  <= !(req_cond_i && !req_write_i);
                wr_n_o  <= !(req_cond_i && req_write_i);
            end else if (state_q == XMP_ST_WAIT && ack_q2) begin
                memory_select_n_o <= SEL_IDLE;
                rd_n_o <= 1'b1;
                wr_n_o <= 1'b1;
            end
        end
    end

    // Read data is sampled at the edge where acknowledge is seen high.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
            done_o  <= 1'b0;
        end else begin
            done_o <= (state_q == XMP_ST_WAIT) && ack_q2;
            if (state_q == XMP_ST_WAIT && ack_q2) begin
                rdata_q <= din_q2;
            end
        end
    end

    // Pin function and flag mode settings, memory mode after reset.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            func_q      <= {DATA_W{XMP_FUNC_MEM}};
            flag_mode_o <= FLAG_MODE_RST;
        end else if (func_we_i) begin
            func_q      <= func_sel_i;
            flag_mode_o <= flag_mode_i;
        end
    end

    // Parallel input word from the upper data pins.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            par_in_word_o  <= '0;
            par_in_valid_o <= 1'b0;
        end else begin
            par_in_valid_o <= par_in_en_i;
            if (par_in_en_i) begin
                par_in_word_o <= din_q2[DATA_W-1:PAR_LO];
            end
        end
    end

    assign flag_in_o = din_q2;

    // Per-pin output mux. Write data lags the strobe edge by one cycle and is
    // held one cycle past it, which gives the memory hold time on the strobe.
    for (genvar i = 0; i < DATA_W; i++) begin : g_pin
        always_ff @(posedge clock_i) begin
            if (!rst_n_i) begin
                data_o[i]    <= 1'b0;
                data_oe_o[i] <= 1'b0;
            end else begin
                unique case (xmp_func_t'(func_q[i*FUNC_W +: FUNC_W]))
                    XMP_FUNC_MEM: begin
                        data_o[i]    <= wdata_q[i];
                        data_oe_o[i] <= mem_drive;
                    end
                    XMP_FUNC_PAR_IN: begin
                        data_o[i]    <= 1'b0;
                        data_oe_o[i] <= 1'b0;
                    end
                    XMP_FUNC_FLAG: begin
                        data_o[i]    <= flag_out_i[i];
                        data_oe_o[i] <= flag_oe_i[i];
                    end
                    XMP_FUNC_PWM: begin
                        data_o[i]    <= pwm_i[i];
                        data_oe_o[i] <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Read words wait here until the core takes them.
    xmp_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rd_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  ((state_q == XMP_ST_DONE) && !write_q && cond_q),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (rdata_q),
        .out_valid_o (rd_valid_o),
        .out_ready_i (rd_ready_i),
        .out_data_o  (rd_data_o)
    );

    // Checks on the pin behaviour.
    AST_ADDR_DRIVEN: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> addr_oe_o)
        else $error("Address pins not driven after reset release.");

    AST_ADDR_FOLLOWS: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        accept |=> (state_q != XMP_ST_IDLE && addr_o == $past(req_addr_i)) ##1
        (state_q != XMP_ST_IDLE && addr_o == $past(req_addr_i, 2)))
        else $error("Address pins do not carry the requested address.");

    AST_IDLE_QUIET: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (state_q == XMP_ST_IDLE) |-> (memory_select_n_o == SEL_IDLE) && rd_n_o && wr_n_o)
        else $error("Select or strobe active while idle.");

    AST_ONE_SELECT: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (state_q == XMP_ST_STROBE) |-> $countones(~memory_select_n_o) == 1)
        else $error("Not exactly one bank select low during an access.");

    AST_READ_STROBE: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (accept && !req_write_i && req_cond_i) |=> !rd_n_o [*2] ##0 wr_n_o)
        else $error("Read strobe missing for a read.");

    AST_WRITE_STROBE: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (accept && req_write_i && req_cond_i) |=> (!wr_n_o && rd_n_o) [*2])
        else $error("Write strobe missing for a write.");

    AST_COND_FALSE: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (accept && !req_cond_i) |=> (memory_select_n_o != SEL_IDLE) && rd_n_o && wr_n_o)
        else $error("False condition must select without strobing.");

    AST_ACK_HOLDS: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (state_q == XMP_ST_WAIT && !ack_q2) |=> (state_q == XMP_ST_WAIT) && $stable(rd_n_o))
        else $error("Access completed while acknowledge low.");

    AST_ACK_ENDS: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (state_q == XMP_ST_WAIT && ack_q2) |=> rd_n_o && wr_n_o && done_o ##1
        (state_q == XMP_ST_IDLE))
        else $error("Strobe not ended one cycle after acknowledge high.");

    AST_PAR_IN_WORD: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        par_in_en_i |=> par_in_valid_o && (par_in_word_o == PAR_W'($past(din_q2) >> PAR_LO)))
        else $error("Parallel input word not taken from upper data pins.");

    AST_MEM_AFTER_RESET: assert property (
        @(posedge clock_i)
        (!$past(rst_n_i) && rst_n_i) |-> (data_oe_o == '0) && (flag_mode_o == FLAG_MODE_RST))
        else $error("Data pins not in memory mode after reset.");

endmodule // xmp_port

// >>> verif/xmp_mem_model.sv
// Behavioural external memory that answers the port's strobes, with wait states.
module xmp_mem_model (
    // Clock.
    input  wire logic        clock_i,
    // Pins driven by the port.
    input  wire logic [3:0]  memory_select_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [31:0] wdata_oe_i,
    // Wait states requested by the bench.
    input  wire logic [7:0]  wait_i,
    // Pins driven back to the port.
    output logic             ack_o,
    output logic             rdrive_o,
    output logic [31:0]      rdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] mem_q [16];
    logic [7:0]  cnt_q;
    logic        strobe;

    // Only a selected device with a strobe low takes part in an access.
    assign strobe = (!rd_n_i || !wr_n_i) && (memory_select_n_i != 4'hf);

    // Count the cycles of the current strobe; saturate so a stuck strobe cannot wrap.
    always_ff @(posedge clock_i) begin
        if (!strobe) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'hff) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // Acknowledge is low for the asked wait states, else pulled high.
    assign ack_o = !(strobe && (cnt_q < wait_i));

    // Take write data only while the port drives every data line.
    always_ff @(posedge clock_i) begin
        if (strobe && !wr_n_i && (&wdata_oe_i)) begin
            mem_q[addr_i[3:0]] <= wdata_i;
        end
    end

    // Read data is driven for the whole read strobe and released after it.
    assign rdrive_o = strobe && !rd_n_i;
    assign rdata_o  = mem_q[addr_i[3:0]];
endmodule // xmp_mem_model

// >>> verif/xmp_port_tb.sv
// Self-checking testbench of the external memory pin port.
module xmp_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import xmp_pkg::*;
    logic              clock_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic              req_valid_i = 1'b0, req_write_i = 1'b0, req_cond_i = 1'b1;
    logic              rd_ready_i = 1'b0, func_we_i = 1'b0, par_in_en_i = 1'b0;
    logic [BANK_W-1:0] req_bank_i = 2'h0;
    logic [ADDR_W-1:0] req_addr_i = 24'h00_0000;
    logic [DATA_W-1:0] req_wdata_i = 32'h0, flag_out_i = 32'h0, flag_oe_i = 32'h0;
    logic [DATA_W-1:0] pwm_i = 32'h0;
    logic [63:0]       func_sel_i = 64'h0;
    logic [3:0]        flag_mode_i = 4'hf;
    logic [7:0]        wait_cyc = 8'h00;
    logic              req_ready_o, done_o, rd_valid_o, par_in_valid_o, addr_oe_o;
    logic              rd_n_o, wr_n_o, ack, rdrive;
    logic [DATA_W-1:0] rd_data_o, flag_in_o, data_o, data_oe_o, rdata, data_pins;
    logic [PAR_W-1:0]  par_in_word_o;
    logic [ADDR_W-1:0] addr_o;
    logic [3:0]        flag_mode_o, memory_select_n_o;
    int                n_mismatch = 0, n_checks = 0, cyc = 0;

    // Clock of 25 ns.
    always #12.5 clock_i = ~clock_i;

    // Data lines carry the port where it drives, else the memory, else the pull-ups.
    assign data_pins = (data_oe_o & data_o) | (~data_oe_o & (rdrive ? rdata : 32'hffff_ffff));

    xmp_port u_xmp_port (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_write_i(req_write_i), .req_cond_i(req_cond_i),
        .req_bank_i(req_bank_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .done_o(done_o), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
        .rd_data_o(rd_data_o), .func_we_i(func_we_i), .func_sel_i(func_sel_i),
        .flag_mode_i(flag_mode_i), .flag_mode_o(flag_mode_o), .par_in_en_i(par_in_en_i),
        .par_in_word_o(par_in_word_o), .par_in_valid_o(par_in_valid_o), .flag_out_i(flag_out_i),
        .flag_oe_i(flag_oe_i), .pwm_i(pwm_i), .flag_in_o(flag_in_o), .addr_o(addr_o),
        .addr_oe_o(addr_oe_o), .memory_select_n_o(memory_select_n_o), .rd_n_o(rd_n_o),
        .wr_n_o(wr_n_o), .ack_i(ack), .data_i(data_pins), .data_o(data_o),
        .data_oe_o(data_oe_o));

    xmp_mem_model u_xmp_mem_model (.clock_i(clock_i), .memory_select_n_i(memory_select_n_o),
        .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .addr_i(addr_o), .wdata_i(data_o),
        .wdata_oe_i(data_oe_o), .wait_i(wait_cyc), .ack_o(ack), .rdrive_o(rdrive),
        .rdata_o(rdata));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    // One access; returns strobe length and which lines were seen active.
    task automatic access(input logic wr, cond, input logic [1:0] bank,
                          input logic [23:0] addr, input logic [31:0] wd,
                          output int strobes, output logic saw_rd, saw_wr, saw_ms);
        int i;
        strobes = 0;
        saw_rd = 1'b0;
        saw_wr = 1'b0;
        saw_ms = 1'b0;
        req_write_i = wr;
        req_cond_i = cond;
        req_bank_i = bank;
        req_addr_i = addr;
        req_wdata_i = wd;
        req_valid_i = 1'b1;
        for (i = 0; i < 40 && req_ready_o !== 1'b1; i++) @(negedge clock_i);
        @(negedge clock_i);
        req_valid_i = 1'b0;
        for (i = 0; i < 60 && done_o !== 1'b1; i++) begin
            if (memory_select_n_o !== 4'hf) begin
                saw_ms = 1'b1;
                check(addr_o === addr && memory_select_n_o === ~(4'h1 << bank),
                      "address or select");
            end
            if (rd_n_o === 1'b0) saw_rd = 1'b1;
            if (wr_n_o === 1'b0) saw_wr = 1'b1;
            if (rd_n_o === 1'b0 || wr_n_o === 1'b0) strobes++;
            @(negedge clock_i);
        end
        check(done_o === 1'b1, "access never completed");
        check(rd_n_o === 1'b1 && wr_n_o === 1'b1 && memory_select_n_o === 4'hf,
              "lines not idle");
    endtask

    task automatic pop_check(input logic [31:0] exp);
        int i;
        for (i = 0; i < 20 && rd_valid_o !== 1'b1; i++) @(negedge clock_i);
        check(rd_valid_o === 1'b1 && rd_data_o === exp, "read data wrong");
        rd_ready_i = 1'b1;
        @(negedge clock_i);
        rd_ready_i = 1'b0;
        @(negedge clock_i);
    endtask

    task automatic t_reset();
        repeat (8) @(negedge clock_i);
        check(addr_oe_o === 1'b0 && data_oe_o === 32'h0, "pins driven in reset");
        check(memory_select_n_o === 4'hf && rd_n_o === 1'b1 && wr_n_o === 1'b1,
              "active in reset");
        check(flag_mode_o === 4'hf, "flag mode default");
        rst_n_i = 1'b1;
        @(negedge clock_i);
        check(addr_oe_o === 1'b1 && addr_o === 24'h00_0000, "address not driven low");
    endtask

    // Flag loopback, parallel input sampling, PWM drive, then back to memory mode.
    task automatic t_pins();
        func_sel_i = {32{2'h2}};
        flag_mode_i = 4'h5;
        flag_out_i = 32'h9abc_def1;
        flag_oe_i = 32'hffff_ffff;
        func_we_i = 1'b1;
        @(negedge clock_i);
        func_we_i = 1'b0;
        repeat (3) @(negedge clock_i);
        check(flag_mode_o === 4'h5, "flag mode not loaded");
        check(data_oe_o === 32'hffff_ffff && flag_in_o === 32'h9abc_def1, "flag path");
        par_in_en_i = 1'b1;
        repeat (2) @(negedge clock_i);
        check(par_in_valid_o === 1'b1 && par_in_word_o === 24'h9a_bcde, "parallel word");
        par_in_en_i = 1'b0;
        func_sel_i = {32{2'h3}};
        pwm_i = 32'h0f0f_3c3c;
        func_we_i = 1'b1;
        @(negedge clock_i);
        func_we_i = 1'b0;
        repeat (2) @(negedge clock_i);
        check(data_o === 32'h0f0f_3c3c && data_oe_o === 32'hffff_ffff, "pwm drive");
        // Upper pins as parallel input, lower as memory; flag enables still all high.
        func_sel_i = {{24{2'h1}}, {8{2'h0}}};
        func_we_i = 1'b1;
        @(negedge clock_i);
        func_we_i = 1'b0;
        repeat (2) @(negedge clock_i);
        check(data_oe_o === 32'h0, "parallel input pins driven");
        func_sel_i = {32{2'h0}};
        flag_oe_i = 32'h0;
        func_we_i = 1'b1;
        @(negedge clock_i);
        func_we_i = 1'b0;
        repeat (2) @(negedge clock_i);
        check(data_oe_o === 32'h0, "memory mode idle still drives");
    endtask

    // False condition: select pulses, no strobe and nothing buffered.
    task automatic t_cond_false();
        int s;
        logic r, w, m;
        access(1'b0, 1'b0, 2'h1, 24'h12_3401, 32'h0, s, r, w, m);
        check(m === 1'b1 && r === 1'b0 && w === 1'b0, "false read lines");
        access(1'b1, 1'b0, 2'h3, 24'h12_3402, 32'h1, s, r, w, m);
        check(m === 1'b1 && r === 1'b0 && w === 1'b0, "false write lines");
        repeat (3) @(negedge clock_i);
        check(rd_valid_o === 1'b0, "false read pushed data");
    endtask

    // Wait states stretch the strobe by exactly the slow cycles of acknowledge.
    task automatic t_wait();
        int s0, s1;
        logic r, w, m;
        access(1'b1, 1'b1, 2'h2, 24'h00_000c, 32'h7e57_a11d, s0, r, w, m);
        access(1'b0, 1'b1, 2'h2, 24'h00_000c, 32'h0, s0, r, w, m);
        wait_cyc = 8'h06;
        access(1'b0, 1'b1, 2'h2, 24'h00_000c, 32'h0, s1, r, w, m);
        wait_cyc = 8'h00;
        check(s1 === s0 + 6, "strobe not held while acknowledge low");
        pop_check(32'h7e57_a11d);
        pop_check(32'h7e57_a11d);
    endtask

    // Eight writes and reads over all banks, a refused ninth read, then drain.
    task automatic t_fifo();
        int s;
        int i;
        logic r, w, m;
        for (i = 0; i < 8; i++) begin
            access(1'b1, 1'b1, i[1:0], 24'(i), 32'hc0de_0000 + i, s, r, w, m);
            check(w === 1'b1 && r === 1'b0 && s >= STROBE_CYC, "write strobe");
        end
        for (i = 0; i < 8; i++) begin
            access(1'b0, 1'b1, i[1:0], 24'(i), 32'h0, s, r, w, m);
            check(r === 1'b1 && w === 1'b0, "read strobe");
        end
        req_write_i = 1'b0;
        req_valid_i = 1'b1;
        repeat (4) @(negedge clock_i);
        check(req_ready_o === 1'b0 && memory_select_n_o === 4'hf,
              "read taken with buffer full");
        req_valid_i = 1'b0;
        for (i = 0; i < 8; i++) pop_check(32'hc0de_0000 + i);
        @(negedge clock_i);
        check(rd_valid_o === 1'b0, "buffer not empty after drain");
    endtask

    // Cut a hang short.
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        t_reset();
        t_pins();
        t_cond_false();
        t_wait();
        t_fifo();
        tally_and_finish();
    end
endmodule // xmp_port_tb
